// ### wdr_ext_source.sv
/*
 * Outside reset source on the open-drain reset line, with its pull-up.
 * Assumes go is a one-cycle pulse from the testbench, set after an edge.
 */
`timescale 1ns/1ps
module wdr_ext_source (
   input wire logic clk,
   input wire logic go,
   input wire logic [7:0] hold_len,
   input wire logic reset_pin_oe,
   input wire logic reset_pin_out,
   output logic reset_pin
);
   logic [7:0] left_ff = 8'h00;

   // Counts down how long the source keeps the line low
   always_ff @(posedge clk) begin
      if (go) begin
         left_ff <= hold_len;
      end else if (left_ff != 8'h00) begin
         left_ff <= left_ff - 8'h01;
      end
   end

   // Wired low by either party, pulled high otherwise
   assign reset_pin = (reset_pin_oe ? reset_pin_out : 1'h1) & (left_ff == 8'h00);
endmodule

// ### wdr_pkg.sv
/*
 * Package for the windowed watchdog and reset-source block: register map,
 * field positions, reset values, timing counts, carrier structs and the
 * timeout lookup functions.
 * Assumes a single 250 MHz clock that also serves as the bus clock.
 */
package wdr_pkg;

   // Clock period in ps, kept for deriving cycle counts
   localparam int CLK_PERIOD_PS = 4000;

   // APB register byte offsets
   localparam logic [7:0] WDR_SERVICE_OFS = 8'h00;
   localparam logic [7:0] WDR_CTRL_OFS = 8'h04;
   localparam logic [7:0] WDR_STATUS_OFS = 8'h08;
   localparam logic [7:0] WDR_COUNT_OFS = 8'h0c;

   // Service sequence keys
   localparam logic [7:0] WDR_KEY_ARM = 8'h55;
   localparam logic [7:0] WDR_KEY_CLEAR = 8'haa;

   // Control register fields
   localparam int CTRL_RATE_LSB = 0;
   localparam int CTRL_INHIBIT_BIT = 2;
   localparam logic [1:0] RATE_RESET = 2'h0;

   // Status register fields
   localparam int ST_PLAIN_EN = 0;
   localparam int ST_WIN_EN = 1;
   localparam int ST_ARMED = 2;
   localparam int ST_WINDOW_OPEN = 3;
   localparam int ST_SRC_EXTERNAL = 4;
   localparam int ST_SRC_INTERNAL = 5;
   localparam int ST_CAUSE_PLAIN = 6;
   localparam int ST_CAUSE_WIN_OVF = 7;
   localparam int ST_CAUSE_WIN_EARLY = 8;
   localparam int ST_CAUSE_CLKMON = 9;
   localparam int ST_INHIBIT = 10;
   localparam int ST_RATE_LOCKED = 11;
   localparam int ST_IN_RESET = 12;

   // Count register fields
   localparam int CNT_WIN_LSB = 0;
   localparam int CNT_PLAIN_LSB = 8;

   // Reset pin timing, in bus clock cycles
   localparam logic [3:0] PIN_DRIVE_CYC = 4'd8;
   localparam logic [3:0] PIN_SAMPLE_CYC = 4'd4;
   localparam int EXT_HOLD_MIN_CYC = 16;

   // Write-once window for the rate field, in bus cycles
   localparam logic [6:0] RATE_WINDOW_CYC = 7'd64;

   // Prescaler widths: core clock divided by 2^17 and 2^14
   localparam int PRESC_W = 17;
   localparam int WIN_PRESC_W = 14;

   // Reset sequencer states, one-hot
   typedef enum logic [3:0] {
      WDR_IDLE = 4'b0001,
      WDR_DRIVE = 4'b0010,
      WDR_SETTLE = 4'b0100,
      WDR_HOLD = 4'b1000
   } wdr_state_t;

   // Nonvolatile and mode settings seen by the block
   typedef struct packed {
      logic plain_watchdog_disable;
      logic windowed_watchdog_disable;
      logic special_mode;
      logic special_test_mode;
   } wdr_cfg_t;

   // Core clock source selection and ticks
   typedef struct packed {
      logic synthesizer_supply_on;
      logic main_clock_select;
      logic bus_clock_select;
      logic pll_output_clock_tick;
      logic crystal_input_clock_tick;
   } wdr_clk_t;

   // Plain watchdog: divided period scaled by 1, 4, 16, 64
   function automatic logic [6:0] wdr_plain_limit(input logic [1:0] rate);
      logic [6:0] lim;
      unique case (rate)
         2'h0: lim = 7'd1;
         2'h1: lim = 7'd4;
         2'h2: lim = 7'd16;
         default: lim = 7'd64;
      endcase
      return lim;
   endfunction

   // Windowed watchdog: divided clock further divided by 8, 32, 64, 128
   function automatic logic [7:0] wdr_win_limit(input logic [1:0] rate);
      logic [7:0] lim;
      unique case (rate)
         2'h0: lim = 8'd8;
         2'h1: lim = 8'd32;
         2'h2: lim = 8'd64;
         default: lim = 8'd128;
      endcase
      return lim;
   endfunction

endpackage

// ### wdr_watchdog.sv
/*
 * Windowed watchdog and reset-source logic with an APB register slave.
 * Holds both watchdog counters, the service sequence, the write-once rate
 * field and the reset pin sequencer that tells external from internal
 * resets.
 * Assumes all inputs synchronous to clk; the core clock arrives as tick
 * enables; the reset pin is resolved outside from oe and out.
 */
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

// Operation
// - On any reset condition drive the reset pin low eight bus cycles, then release.
// - Four cycles after release sample pin; low means external, high internal.
// - An enabled watchdog whose counter times out starts a system reset.
// - Watchdog enables follow disable settings latched at reset only.
// - Special modes start with watchdog resets inhibited; writing zero allows them.
// - Plain watchdog counts core clock over 2^17, windowed over 2^14.
// - Core clock is PLL when synthesizer on and both selects set, else crystal.
// - Rate field resets to zero; normal modes allow one write within 64 cycles.
// - Plain watchdog rate values scale the divided period by 1, 4, 16, 64.
// - Windowed watchdog rate values divide its clock by 8, 32, 64, 128.
// - Timeout may be late by one divided period, never early.
// - One rate field is shared by both watchdogs.
// - Windowed watchdog has priority; plain watchdog then never causes reset.
// - Windowed service window is the latter half of each timeout period.
// - Early windowed service resets system; in-window service restarts at zero.
// - Windowed watchdog is enabled after reset except in special test mode.
// - Build option forces windowed watchdog on in normal modes only.
// - Windowed watchdog stops and raises no reset while the CPU waits.
// - A set disable bit turns that watchdog off; clear means enabled.
module wdr_watchdog #(
   parameter bit FORCE_WINDOWED = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire wdr_pkg::wdr_cfg_t cfg,
   input wire wdr_pkg::wdr_clk_t core_clk,
   input wire logic cpu_wait,
   input wire logic clock_monitor_fail,
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic system_reset,
   output logic reset_source_external
);
   import wdr_pkg::*;

   wdr_state_t state_ff;
   logic [3:0] pin_cnt_ff;
   logic sys_reset_ff;
   logic pin_oe_ff;
   logic src_ext_ff;
   logic src_int_ff;
   logic [3:0] cause_ff;
   logic latch_pending_ff;
   logic plain_en_ff;
   logic win_en_ff;
   logic inhibit_ff;
   logic [1:0] rate_ff;
   logic rate_locked_ff;
   logic [6:0] rate_win_cnt_ff;
   logic [PRESC_W-1:0] presc_ff;
   logic [6:0] plain_cnt_ff;
   logic [7:0] win_cnt_ff;
   logic armed_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   logic core_tick;
   logic win_tick;
   logic plain_tick;
   logic wr_access;
   logic svc_wr;
   logic serviced;
   logic [7:0] win_lim;
   logic [6:0] plain_lim;
   logic window_open;
   logic win_ovf;
   logic win_early;
   logic plain_ovf;
   logic wd_req;
   logic any_req;
   logic [3:0] nxt_cause;

   // Core clock source: PLL only when synthesizer runs and both selects set
   assign core_tick = (core_clk.synthesizer_supply_on && core_clk.main_clock_select
                       && core_clk.bus_clock_select) ? core_clk.pll_output_clock_tick
                                                     : core_clk.crystal_input_clock_tick;

   // Divided watchdog clocks taken from the shared prescaler
   assign win_tick = core_tick && (&presc_ff[WIN_PRESC_W-1:0]);
   assign plain_tick = core_tick && (&presc_ff);

   // Register write strobe at the access edge of a completed transfer
   assign wr_access = psel && penable && pready_ff && pwrite;
   assign svc_wr = wr_access && (paddr == WDR_SERVICE_OFS);
   assign serviced = svc_wr && armed_ff && (pwdata[7:0] == WDR_KEY_CLEAR);

   // Shared rate field gives both limits
   assign win_lim = wdr_win_limit(rate_ff);
   assign plain_lim = wdr_plain_limit(rate_ff);

   // Window opens at half the windowed timeout
   // A service landing exactly on the half mark counts as inside the window
   assign window_open = win_cnt_ff >= {1'b0, win_lim[7:1]};

   // Windowed events are suppressed while the CPU waits
   assign win_ovf = win_en_ff && !cpu_wait && win_tick
                    && (win_cnt_ff == win_lim - 8'd1);
   assign win_early = win_en_ff && !cpu_wait && serviced && !window_open;
   // Plain watchdog is redundant whenever the windowed one runs
   assign plain_ovf = plain_en_ff && !win_en_ff && plain_tick
                      && (plain_cnt_ff == plain_lim - 7'd1);

   // Watchdog requests are blocked while resets are inhibited
   assign wd_req = !inhibit_ff && (win_ovf || win_early || plain_ovf);
   assign any_req = wd_req || clock_monitor_fail;

   // Internal cause recorded with the request that starts the sequence
   always_comb begin
      nxt_cause = 4'h0;
      if (!inhibit_ff) begin
         nxt_cause[0] = plain_ovf;
         nxt_cause[1] = win_ovf;
         nxt_cause[2] = win_early;
      end
      nxt_cause[3] = clock_monitor_fail;
   end

   // Reset pin sequencer: drive, release, sample, wait for external release
   // Requests during a running sequence are dropped; it already resets everything
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= WDR_IDLE;
         pin_cnt_ff <= 4'h0;
      end else begin
         unique case (state_ff)
            WDR_IDLE: begin
               if (any_req || !reset_pin_in) begin
                  state_ff <= WDR_DRIVE;
                  pin_cnt_ff <= PIN_DRIVE_CYC - 4'd1;
               end
            end
            WDR_DRIVE: begin
               if (pin_cnt_ff == 4'h0) begin
                  state_ff <= WDR_SETTLE;
                  pin_cnt_ff <= PIN_SAMPLE_CYC - 4'd1;
               end else begin
                  pin_cnt_ff <= pin_cnt_ff - 4'd1;
               end
            end
            WDR_SETTLE: begin
               if (pin_cnt_ff == 4'h0) begin
                  // Low pin means an external source still holds it
                  state_ff <= reset_pin_in ? WDR_IDLE : WDR_HOLD;
               end else begin
                  pin_cnt_ff <= pin_cnt_ff - 4'd1;
               end
            end
            WDR_HOLD: begin
               if (reset_pin_in) begin
                  state_ff <= WDR_IDLE;
               end
            end
         endcase
      end
   end

   // Pin drive and system reset level, both from flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_oe_ff <= 1'b0;
         sys_reset_ff <= 1'b0;
      end else begin
         pin_oe_ff <= (state_ff == WDR_IDLE) ? (any_req || !reset_pin_in)
                    : ((state_ff == WDR_DRIVE) && (pin_cnt_ff != 4'h0));
         sys_reset_ff <= (state_ff == WDR_IDLE) ? (any_req || !reset_pin_in)
                       : !((state_ff == WDR_SETTLE) && (pin_cnt_ff == 4'h0) && reset_pin_in)
                         && !((state_ff == WDR_HOLD) && reset_pin_in);
      end
   end

   // Reset cause latched at the sequence start, source decided at the sample point
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         src_ext_ff <= 1'b0;
         src_int_ff <= 1'b0;
         cause_ff <= 4'h0;
      end else if ((state_ff == WDR_IDLE) && (any_req || !reset_pin_in)) begin
         cause_ff <= nxt_cause;
      end else if ((state_ff == WDR_SETTLE) && (pin_cnt_ff == 4'h0)) begin
         src_ext_ff <= !reset_pin_in;
         src_int_ff <= reset_pin_in;
      end
   end

   // Nonvolatile settings latched once per reset, on the release
   // Enables stay clear during system reset so no watchdog counts inside it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_pending_ff <= 1'b1;
         plain_en_ff <= 1'b0;
         win_en_ff <= 1'b0;
      end else if (sys_reset_ff) begin
         latch_pending_ff <= 1'b1;
         plain_en_ff <= 1'b0;
         win_en_ff <= 1'b0;
      end else if (latch_pending_ff) begin
         latch_pending_ff <= 1'b0;
         plain_en_ff <= !cfg.plain_watchdog_disable;
         if (cfg.special_test_mode) begin
            win_en_ff <= 1'b0;
         end else if (FORCE_WINDOWED && !cfg.special_mode) begin
            win_en_ff <= 1'b1;
         end else begin
            win_en_ff <= !cfg.windowed_watchdog_disable;
         end
      end
   end

   // Reset inhibit: set on entry in special modes, cleared by software
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         inhibit_ff <= 1'b0;
      end else if (latch_pending_ff && !sys_reset_ff) begin
         inhibit_ff <= cfg.special_mode;
      end else if (wr_access && (paddr == WDR_CTRL_OFS) && cfg.special_mode) begin
         inhibit_ff <= pwdata[CTRL_INHIBIT_BIT];
      end
   end

   // Rate field: write once within the first bus cycles in normal modes
   // Special modes leave the field writable and never lock it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rate_ff <= RATE_RESET;
         rate_locked_ff <= 1'b0;
         rate_win_cnt_ff <= 7'h0;
      end else if (sys_reset_ff) begin
         rate_ff <= RATE_RESET;
         rate_locked_ff <= 1'b0;
         rate_win_cnt_ff <= 7'h0;
      end else begin
         if (rate_win_cnt_ff != RATE_WINDOW_CYC) begin
            rate_win_cnt_ff <= rate_win_cnt_ff + 7'd1;
         end
         if (wr_access && (paddr == WDR_CTRL_OFS)) begin
            if (cfg.special_mode) begin
               rate_ff <= pwdata[CTRL_RATE_LSB +: 2];
            end else if (!rate_locked_ff && (rate_win_cnt_ff != RATE_WINDOW_CYC)) begin
               rate_ff <= pwdata[CTRL_RATE_LSB +: 2];
               rate_locked_ff <= 1'b1;
            end
         end
      end
   end

   // Service arming: 55 arms, AA clears the counters when armed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_ff <= 1'b0;
      end else if (sys_reset_ff) begin
         armed_ff <= 1'b0;
      end else if (svc_wr) begin
         if (pwdata[7:0] == WDR_KEY_ARM) begin
            armed_ff <= 1'b1;
         end else if (pwdata[7:0] == WDR_KEY_CLEAR) begin
            armed_ff <= 1'b0;
         end
      end
   end

   // Prescaler restarts on service so a timeout is never early
   // One prescaler feeds both dividers; the windowed tick taps its low bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         presc_ff <= '0;
      end else if (sys_reset_ff || serviced) begin
         presc_ff <= '0;
      end else if (core_tick) begin
         presc_ff <= presc_ff + 1'b1;
      end
   end

   // Plain watchdog counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         plain_cnt_ff <= 7'h0;
      end else if (sys_reset_ff || serviced || !plain_en_ff) begin
         plain_cnt_ff <= 7'h0;
      end else if (plain_tick && (plain_cnt_ff != plain_lim - 7'd1)) begin
         plain_cnt_ff <= plain_cnt_ff + 7'd1;
      end
   end

   // Windowed watchdog counter, frozen while the CPU waits
   // It saturates at one below the limit, so it cannot wrap back into the closed half
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         win_cnt_ff <= 8'h0;
      end else if (sys_reset_ff || serviced || !win_en_ff) begin
         win_cnt_ff <= 8'h0;
      end else if (win_tick && !cpu_wait && (win_cnt_ff != win_lim - 8'd1)) begin
         win_cnt_ff <= win_cnt_ff + 8'd1;
      end
   end

   // APB slave: one wait-free access phase, read data latched in setup
   // Status is captured in the setup cycle, one cycle before software sees it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0;
      end else begin
         pready_ff <= psel && !penable;
         if (psel && !penable) begin
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
            unique case (paddr)
               WDR_SERVICE_OFS: prdata_ff <= 32'h0;
               WDR_CTRL_OFS: begin
                  prdata_ff[CTRL_RATE_LSB +: 2] <= rate_ff;
                  prdata_ff[CTRL_INHIBIT_BIT] <= inhibit_ff;
               end
               WDR_STATUS_OFS: begin
                  prdata_ff[ST_PLAIN_EN] <= plain_en_ff;
                  prdata_ff[ST_WIN_EN] <= win_en_ff;
                  prdata_ff[ST_ARMED] <= armed_ff;
                  prdata_ff[ST_WINDOW_OPEN] <= window_open;
                  prdata_ff[ST_SRC_EXTERNAL] <= src_ext_ff;
                  prdata_ff[ST_SRC_INTERNAL] <= src_int_ff;
                  prdata_ff[ST_CAUSE_PLAIN] <= cause_ff[0];
                  prdata_ff[ST_CAUSE_WIN_OVF] <= cause_ff[1];
                  prdata_ff[ST_CAUSE_WIN_EARLY] <= cause_ff[2];
                  prdata_ff[ST_CAUSE_CLKMON] <= cause_ff[3];
                  prdata_ff[ST_INHIBIT] <= inhibit_ff;
                  prdata_ff[ST_RATE_LOCKED] <= rate_locked_ff;
                  prdata_ff[ST_IN_RESET] <= sys_reset_ff;
               end
               WDR_COUNT_OFS: begin
                  prdata_ff[CNT_WIN_LSB +: 8] <= win_cnt_ff;
                  prdata_ff[CNT_PLAIN_LSB +: 7] <= plain_cnt_ff;
               end
               default: pslverr_ff <= 1'b1; // Unmapped offset
            endcase
         end
      end
   end

   // Outputs straight from their flops; the pin itself only ever pulls low
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign reset_pin_out = 1'b0; // Open-drain: only the enable moves
   assign reset_pin_oe = pin_oe_ff;
   assign system_reset = sys_reset_ff;
   assign reset_source_external = src_ext_ff;

endmodule

// ### wdr_watchdog_properties.sv
/*
 * Property checker for the reset pin sequencer and the APB ready pulse.
 * Assumes it is bound to wdr_watchdog and sees that module's ports only.
 */
`timescale 1ns/1ps
module wdr_watchdog_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic clock_monitor_fail,
   input wire logic reset_pin_in,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic system_reset,
   input wire logic reset_source_external
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Pin sequence: drive span, release gap, sample and its verdict
   a_pin_drive: assert property ($rose(reset_pin_oe) |->
      reset_pin_oe [*8] ##1 !reset_pin_oe) else $error("reset pin drive length wrong");
   a_release_gap: assert property ($fell(reset_pin_oe) |->
      (!reset_pin_oe && system_reset) [*4]) else $error("release gap broken");
   a_int_source: assert property ($fell(reset_pin_oe) ##3 reset_pin_in |=>
      !system_reset && !reset_source_external) else $error("internal reset not ended");
   a_ext_hold: assert property ($fell(reset_pin_oe) ##3 !reset_pin_in |=>
      system_reset && !reset_pin_oe) else $error("external reset not held");

   // Start of a sequence from its causes
   a_clkmon_start: assert property (!system_reset && clock_monitor_fail |=>
      reset_pin_oe && system_reset) else $error("clock monitor request lost");
   a_pin_start: assert property (!system_reset && !reset_pin_in |=>
      reset_pin_oe) else $error("external request lost");
   a_open_drain: assert property (reset_pin_oe |->
      !reset_pin_out && system_reset) else $error("pin driven without reset");

   // Ready stands one cycle after setup; a stuck ready would hide write timing
   a_ready_pulse: assert property (psel && !penable |=>
      pready ##1 !pready) else $error("pready not a single pulse");
endmodule

bind wdr_watchdog wdr_watchdog_properties i_props (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
   .clock_monitor_fail(clock_monitor_fail), .reset_pin_in(reset_pin_in),
   .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
   .system_reset(system_reset), .reset_source_external(reset_source_external)
);

// ### windowed_watchdog_reset_test.sv
/*
 * Self-checking testbench for the watchdog and reset-source block.
 * Assumes the APB slave answers after one wait-free access cycle, the
 * outside source model on the pin and the bound property checker.
 */
`timescale 1ns/1ps
module windowed_watchdog_reset_test;
   import wdr_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, cpu_wait, cmon_fail;
   logic [7:0] paddr, hold_len;
   logic [31:0] pwdata, prdata, q;
   wdr_cfg_t cfg;
   wdr_clk_t core_clk;
   logic pin, pin_out, pin_oe, sys_rst, src_ext, ext_go, e;
   int err_count = 0;
   int n_checks = 0;
   int on, tot;

   wdr_watchdog i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cfg(cfg), .core_clk(core_clk), .cpu_wait(cpu_wait),
      .clock_monitor_fail(cmon_fail), .reset_pin_in(pin), .reset_pin_out(pin_out),
      .reset_pin_oe(pin_oe), .system_reset(sys_rst), .reset_source_external(src_ext));
   wdr_ext_source i_src (.clk(clk), .go(ext_go), .hold_len(hold_len),
      .reset_pin_oe(pin_oe), .reset_pin_out(pin_out), .reset_pin(pin));

   // 250 MHz clock
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; an idle cycle follows so strobes never toggle twice at once
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      chk(n, 32'h1, "access cycles");
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask

   task automatic svc(input logic [7:0] v);
      apb(1'h1, WDR_SERVICE_OFS, {24'h0, v});
   endtask

   // Counts pin drive cycles and total reset length of one sequence
   task automatic seq();
      int w;
      w = 0;
      on = 1;
      tot = 0;
      while (pin_oe !== 1'h1 && w < 40) begin
         @(posedge clk);
         w++;
      end
      while (sys_rst === 1'h1 && tot < 300) begin
         @(posedge clk);
         tot++;
         if (pin_oe === 1'h1) on++;
      end
   endtask

   task automatic cmon_reset();
      cmon_fail <= 1'h1;
      @(posedge clk);
      cmon_fail <= 1'h0;
      seq();
      chk(on, PIN_DRIVE_CYC, "drive cycles");
      chk(tot, PIN_DRIVE_CYC + PIN_SAMPLE_CYC, "reset length");
      chk(src_ext, 1'h0, "source external");
   endtask

   task automatic t_reset_vals();
      apb(1'h0, WDR_CTRL_OFS, 32'h0);
      chk(q[1:0], RATE_RESET, "rate");
      apb(1'h0, WDR_STATUS_OFS, 32'h0);
      chk(q[ST_WIN_EN], 1'h1, "win_en");
      chk(q[ST_PLAIN_EN], 1'h1, "plain_en");
      apb(1'h0, 8'h10, 32'h0);
      chk(e, 1'h1, "pslverr");
      $display("test reset_vals done");
   endtask

   task automatic t_rate_once();
      apb(1'h1, WDR_CTRL_OFS, 32'h2);
      apb(1'h0, WDR_CTRL_OFS, 32'h0);
      chk(q[1:0], 2'h2, "rate first");
      apb(1'h1, WDR_CTRL_OFS, 32'h7);
      apb(1'h0, WDR_CTRL_OFS, 32'h0);
      chk(q[1:0], 2'h2, "rate second");
      apb(1'h0, WDR_STATUS_OFS, 32'h0);
      chk(q[ST_INHIBIT], 1'h0, "inhibit normal");
      $display("test rate_once done");
   endtask

   task automatic t_clkmon();
      cmon_reset();
      apb(1'h0, WDR_STATUS_OFS, 32'h0);
      chk(q[ST_SRC_INTERNAL], 1'h1, "src internal");
      chk(q[ST_CAUSE_CLKMON], 1'h1, "cause clkmon");
      apb(1'h0, WDR_CTRL_OFS, 32'h0);
      chk(q[1:0], RATE_RESET, "rate after reset");
      $display("test clkmon done");
   endtask

   task automatic t_external();
      hold_len <= 8'(EXT_HOLD_MIN_CYC) + 8'h04;
      ext_go <= 1'h1;
      @(posedge clk);
      ext_go <= 1'h0;
      seq();
      chk(on, PIN_DRIVE_CYC, "drive cycles ext");
      chk(src_ext, 1'h1, "source external");
      $display("test external done");
   endtask

   task automatic t_early();
      svc(WDR_KEY_ARM);
      apb(1'h0, WDR_STATUS_OFS, 32'h0);
      chk(q[ST_ARMED], 1'h1, "armed");
      svc(8'h12);
      svc(WDR_KEY_CLEAR);
      seq();
      chk(on, PIN_DRIVE_CYC, "drive cycles early");
      apb(1'h0, WDR_STATUS_OFS, 32'h0);
      chk(q[ST_CAUSE_WIN_EARLY], 1'h1, "cause early");
      $display("test early done");
   endtask

   // Early service while the CPU waits must not reset
   task automatic t_wait();
      cpu_wait <= 1'h1;
      svc(WDR_KEY_ARM);
      svc(WDR_KEY_CLEAR);
      repeat (4) @(posedge clk);
      chk(sys_rst, 1'h0, "no reset in wait");
      cpu_wait <= 1'h0;
      $display("test wait done");
   endtask

   task automatic t_latch();
      cfg <= 4'h4;
      apb(1'h0, WDR_STATUS_OFS, 32'h0);
      chk(q[ST_WIN_EN], 1'h1, "win_en before reset");
      cmon_reset();
      apb(1'h0, WDR_STATUS_OFS, 32'h0);
      chk(q[ST_WIN_EN], 1'h0, "win_en after reset");
      chk(q[ST_PLAIN_EN], 1'h1, "plain_en");
      svc(WDR_KEY_ARM);
      svc(WDR_KEY_CLEAR);
      repeat (6) @(posedge clk);
      chk(sys_rst, 1'h0, "no reset plain");
      $display("test latch done");
   endtask

   task automatic t_special();
      cfg <= 4'h2;
      cmon_reset();
      apb(1'h0, WDR_STATUS_OFS, 32'h0);
      chk(q[ST_INHIBIT], 1'h1, "inhibit special");
      svc(WDR_KEY_ARM);
      svc(WDR_KEY_CLEAR);
      repeat (6) @(posedge clk);
      chk(sys_rst, 1'h0, "no reset inhibited");
      apb(1'h1, WDR_CTRL_OFS, 32'h0);
      svc(WDR_KEY_ARM);
      svc(WDR_KEY_CLEAR);
      seq();
      chk(on, PIN_DRIVE_CYC, "reset allowed");
      cfg <= 4'h3;
      cmon_reset();
      apb(1'h0, WDR_STATUS_OFS, 32'h0);
      chk(q[ST_WIN_EN], 1'h0, "win_en test mode");
      $display("test special done");
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Main sequence; ticks every cycle keep the core clock alive
   initial begin
      rst_n = 1'h0;
      {psel, penable, pwrite, cpu_wait, cmon_fail, ext_go} = 6'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      hold_len = 8'h0;
      cfg = 4'h0;
      core_clk = 5'h01;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      t_reset_vals();
      t_rate_once();
      t_clkmon();
      t_external();
      t_early();
      t_wait();
      t_latch();
      t_special();
      close_out();
   end

   // Whole run needs well under 2000 cycles
   initial begin
      #20000;
      err_count++;
      close_out();
   end
endmodule
